// [design/hpb_consts.svh]
// Offsets, field positions, reset values and timing counts of the bridge
// configuration header. Definitions only; included by bare name.
`ifndef HPB_CONSTS_SVH
`define HPB_CONSTS_SVH

// Configuration offsets, one byte each.
`define HPB_OFF_REVISION 8'h08
`define HPB_OFF_SUBCLASS 8'h0a
`define HPB_OFF_BASECLASS 8'h0b
`define HPB_OFF_PRI_LAT 8'h0d
`define HPB_OFF_HEADER 8'h0e
`define HPB_OFF_UP_BUS 8'h18
`define HPB_OFF_DOWN_BUS 8'h19
`define HPB_OFF_SUB_BUS 8'h1a
`define HPB_OFF_SEC_LAT 8'h1b
`define HPB_OFF_IO_BASE 8'h1c
`define HPB_OFF_IO_LIMIT 8'h1d

// Fixed and reset values.
`define HPB_REVISION_DEFAULT 8'h00
`define HPB_SUBCLASS_VAL 8'h04
`define HPB_BASECLASS_VAL 8'h06
`define HPB_PRI_LAT_VAL 8'h00
`define HPB_HEADER_VAL 8'h01
`define HPB_UP_BUS_VAL 8'h00
`define HPB_DOWN_BUS_RST 8'h00
`define HPB_SUB_BUS_RST 8'h00
`define HPB_SEC_LAT_RST 5'h00
`define HPB_IO_BASE_RST 4'hf
`define HPB_IO_LIMIT_RST 4'h0

// Field positions.
`define HPB_LAT_MSB 7
`define HPB_LAT_LSB 3
`define HPB_IO_MSB 7
`define HPB_IO_LSB 4
`define HPB_IO_CAP_VAL 4'h0
`define HPB_IO_BASE_PAD 12'h000
`define HPB_IO_LIMIT_PAD 12'hfff

// Latency count unit in PCI clocks, as a shift of the count field.
`define HPB_TENURE_UNIT_CLKS 8
`define HPB_TENURE_SHIFT 3

`endif

// [design/hpb_pkg.sv]
// Types shared by the bridge configuration header modules.
// Assumes hpb_consts.svh carries the numeric constants.
package hpb_pkg;

  typedef enum logic [1:0] {
    HPB_TMR_IDLE,
    HPB_TMR_COUNT,
    HPB_TMR_EXPIRED
  } hpb_tmr_state_t;

  typedef logic [7:0] hpb_byte_t;

endpackage

// [design/hpb_tenure_timer.sv]
// Secondary-side master tenure counter of the bridge.
// Assumes frame_start_i pulses in the cycle the bridge asserts FRAME#
// after being granted, and frame_active_i is high while it holds FRAME#.
`timescale 1ns/1ns
`include "hpb_consts.svh"

module hpb_tenure_timer (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Master cycle control
  input wire logic frame_start_i,
  input wire logic frame_active_i,
  input wire logic grant_i,
  input wire logic [4:0] latency_count_i,
  // Status
  output logic tenure_expired_o,
  output logic frame_release_o,
  output logic [7:0] tenure_counter_o
);

  hpb_pkg::hpb_tmr_state_t state;
  hpb_pkg::hpb_tmr_state_t next_state;
  logic [7:0] tenure_counter;
  logic [7:0] next_tenure_counter;
  logic [7:0] load_value;

  assign load_value = {latency_count_i, 3'h0};

  always_comb begin
    next_state = state;
    next_tenure_counter = tenure_counter;
    case (state)
      hpb_pkg::HPB_TMR_IDLE: begin
        if (frame_start_i) begin
          next_tenure_counter = load_value; // [R9] [R11]
          next_state = (load_value == 8'h00) ? hpb_pkg::HPB_TMR_EXPIRED
                                             : hpb_pkg::HPB_TMR_COUNT;
        end
      end
      hpb_pkg::HPB_TMR_COUNT: begin
        if (!frame_active_i) begin
          next_state = hpb_pkg::HPB_TMR_IDLE;
        end else begin
          next_tenure_counter = tenure_counter - 8'h01; // [R9]
          if (tenure_counter == 8'h01) begin
            next_state = hpb_pkg::HPB_TMR_EXPIRED;
          end
        end
      end
      hpb_pkg::HPB_TMR_EXPIRED: begin
        if (!frame_active_i) begin
          next_state = hpb_pkg::HPB_TMR_IDLE;
        end
      end
      default: begin
        next_state = hpb_pkg::HPB_TMR_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state <= hpb_pkg::HPB_TMR_IDLE;
      tenure_counter <= 8'h00;
    end else begin
      state <= next_state;
      tenure_counter <= next_tenure_counter;
    end
  end

  // With the grant still held the bridge keeps bursting past expiry.
  assign tenure_expired_o = (state == hpb_pkg::HPB_TMR_EXPIRED);
  assign frame_release_o = tenure_expired_o && frame_active_i && !grant_i; // [R10]
  assign tenure_counter_o = tenure_counter;

endmodule

// [design/hpb_cycle_decode.sv]
// Registered decode of hub configuration and I/O cycles against the
// bus numbers and I/O window held in the configuration header.
// Assumes requests are single-cycle valid pulses on the bridge clock.
`timescale 1ns/1ns
`include "hpb_consts.svh"

module hpb_cycle_decode (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Header state
  input wire logic [7:0] downstream_bus_i,
  input wire logic [7:0] subordinate_bus_i,
  input wire logic [15:0] io_window_lo_i,
  input wire logic [15:0] io_window_hi_i,
  // Hub configuration cycle
  input wire logic cfg_cycle_valid_i,
  input wire logic [7:0] cfg_cycle_bus_i,
  // Hub I/O cycle
  input wire logic io_cycle_valid_i,
  input wire logic [15:0] io_cycle_addr_i,
  // Decode results
  output logic cfg_result_valid_o,
  output logic cfg_as_type0_o,
  output logic cfg_as_type1_o,
  output logic cfg_master_abort_o,
  output logic io_result_valid_o,
  output logic io_forward_o
);

  // Inclusive range check shared by bus and I/O decode.
  function automatic logic in_range(input logic [15:0] v, input logic [15:0] lo,
                                    input logic [15:0] hi);
    in_range = (v >= lo) && (v <= hi);
  endfunction

  logic next_cfg_valid;
  logic next_type0;
  logic next_type1;
  logic next_abort;
  logic next_io_valid;
  logic next_io_forward;
  logic bus_hit;

  always_comb begin
    bus_hit = in_range({8'h00, cfg_cycle_bus_i}, {8'h00, downstream_bus_i},
                       {8'h00, subordinate_bus_i});
    next_cfg_valid = cfg_cycle_valid_i;
    next_type0 = 1'b0;
    next_type1 = 1'b0;
    next_abort = 1'b0;
    if (cfg_cycle_valid_i) begin
      if (!bus_hit) begin
        next_abort = 1'b1; // [R8]
      end else if (cfg_cycle_bus_i == downstream_bus_i &&
                   downstream_bus_i != `HPB_UP_BUS_VAL) begin
        next_type0 = 1'b1;
      end else begin
        next_type1 = 1'b1; // [R7]
      end
    end
    next_io_valid = io_cycle_valid_i;
    next_io_forward = io_cycle_valid_i &&
                      in_range(io_cycle_addr_i, io_window_lo_i, io_window_hi_i); // [R15]
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      cfg_result_valid_o <= 1'b0;
      cfg_as_type0_o <= 1'b0;
      cfg_as_type1_o <= 1'b0;
      cfg_master_abort_o <= 1'b0;
      io_result_valid_o <= 1'b0;
      io_forward_o <= 1'b0;
    end else begin
      cfg_result_valid_o <= next_cfg_valid;
      cfg_as_type0_o <= next_type0;
      cfg_as_type1_o <= next_type1;
      cfg_master_abort_o <= next_abort;
      io_result_valid_o <= next_io_valid;
      io_forward_o <= next_io_forward;
    end
  end

endmodule

// [design/hpb_config_header.sv]
// Configuration header of the hub-to-PCI bridge function: identity and
// class bytes, bus numbering, secondary latency timer and I/O window.
// Assumes configuration accesses arrive as byte requests from the hub
// interface logic on the same clock, and that the PCI master engine
// reports its frame activity on that clock as well.
//
// Summary of operation
// [R1] Revision byte is read-only, set by parameter.
// [R2] Sub-class byte reads fixed PCI-to-PCI bridge code.
// [R3] Base class byte reads fixed bridge code.
// [R4] Primary latency timer reads zero always.
// [R5] Header type reads single-function bridge layout.
// [R6] Primary bus number hardwired to zero.
// [R7] Secondary bus writable; equal to primary gives Type 1.
// [R8] Subordinate writable; out-of-range Type 1 master-aborts.
// [R9] Load tenure counter at FRAME# start, count down.
// [R10] Expiry without grant releases FRAME#; else continue.
// [R11] Latency count bits 7:3, eight-clock units.
// [R12] I/O base bits 7:4, low bits zero.
// [R13] I/O limit bits 7:4, low bits ones.
// [R14] I/O capability nibbles read zero, 16-bit only.
// [R15] Hub I/O within padded window is forwarded.
// [R16] Writes to read-only fields are ignored.
`timescale 1ns/1ns
`include "hpb_consts.svh"

module hpb_config_header #(
  // Revision of the bridge function; the value is arbitrary.
  parameter logic [7:0] REVISION_CODE = `HPB_REVISION_DEFAULT
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Configuration access from the hub interface
  input wire logic cfg_valid_i,
  input wire logic cfg_write_i,
  input wire logic [7:0] cfg_offset_i,
  input wire logic [7:0] cfg_wdata_i,
  output logic cfg_done_o,
  output logic [7:0] cfg_rdata_o,
  // Hub configuration cycle to decode
  input wire logic hub_cfg_valid_i,
  input wire logic [7:0] hub_cfg_bus_i,
  output logic hub_cfg_result_o,
  output logic hub_cfg_type0_o,
  output logic hub_cfg_type1_o,
  output logic hub_cfg_abort_o,
  // Hub I/O cycle to decode
  input wire logic hub_io_valid_i,
  input wire logic [15:0] hub_io_addr_i,
  output logic hub_io_result_o,
  output logic hub_io_forward_o,
  // Secondary PCI master tenure
  input wire logic frame_start_i,
  input wire logic frame_active_i,
  input wire logic grant_i,
  output logic tenure_expired_o,
  output logic frame_release_o,
  // Header state for the forwarding logic
  output logic [7:0] downstream_bus_number_o,
  output logic [7:0] highest_bus_below_o,
  output logic [15:0] io_window_lo_o,
  output logic [15:0] io_window_hi_o
);

  // ------------------------------------------------------------------
  // Register state
  // ------------------------------------------------------------------

  logic [7:0] downstream_bus_number;
  logic [7:0] highest_bus_below;
  logic [4:0] latency_count;
  logic [3:0] io_base_hi;
  logic [3:0] io_limit_hi;
  logic [7:0] next_downstream_bus_number;
  logic [7:0] next_highest_bus_below;
  logic [4:0] next_latency_count;
  logic [3:0] next_io_base_hi;
  logic [3:0] next_io_limit_hi;

  logic cfg_done;
  logic [7:0] cfg_rdata;
  logic next_cfg_done;
  logic [7:0] next_cfg_rdata;

  logic wr_en;
  logic rd_en;

  assign wr_en = cfg_valid_i && cfg_write_i;
  assign rd_en = cfg_valid_i && !cfg_write_i;

  // ------------------------------------------------------------------
  // Register images
  // ------------------------------------------------------------------

  // Full byte as software sees it; unmapped offsets read zero.
  function automatic logic [7:0] read_image(input logic [7:0] off,
                                            input logic [7:0] rev,
                                            input logic [7:0] dbus,
                                            input logic [7:0] sbus,
                                            input logic [4:0] lat,
                                            input logic [3:0] base,
                                            input logic [3:0] limit);
    case (off)
      `HPB_OFF_REVISION: read_image = rev;
      `HPB_OFF_SUBCLASS: read_image = `HPB_SUBCLASS_VAL;
      `HPB_OFF_BASECLASS: read_image = `HPB_BASECLASS_VAL;
      `HPB_OFF_PRI_LAT: read_image = `HPB_PRI_LAT_VAL;
      `HPB_OFF_HEADER: read_image = `HPB_HEADER_VAL;
      `HPB_OFF_UP_BUS: read_image = `HPB_UP_BUS_VAL;
      `HPB_OFF_DOWN_BUS: read_image = dbus;
      `HPB_OFF_SUB_BUS: read_image = sbus;
      `HPB_OFF_SEC_LAT: read_image = {lat, 3'h0};
      `HPB_OFF_IO_BASE: read_image = {base, `HPB_IO_CAP_VAL};
      `HPB_OFF_IO_LIMIT: read_image = {limit, `HPB_IO_CAP_VAL};
      default: read_image = 8'h00;
    endcase
  endfunction

  // ------------------------------------------------------------------
  // Configuration write path
  // ------------------------------------------------------------------

  // Only the writable fields have storage, so a write to any fixed byte,
  // reserved bit or capability nibble has nothing to land in.
  always_comb begin
    next_downstream_bus_number = downstream_bus_number;
    next_highest_bus_below = highest_bus_below;
    next_latency_count = latency_count;
    next_io_base_hi = io_base_hi;
    next_io_limit_hi = io_limit_hi;
    if (wr_en) begin
      case (cfg_offset_i)
        `HPB_OFF_DOWN_BUS: begin
          next_downstream_bus_number = cfg_wdata_i; // [R7]
        end
        `HPB_OFF_SUB_BUS: begin
          next_highest_bus_below = cfg_wdata_i; // [R8]
        end
        `HPB_OFF_SEC_LAT: begin
          next_latency_count = cfg_wdata_i[`HPB_LAT_MSB:`HPB_LAT_LSB]; // [R11]
        end
        `HPB_OFF_IO_BASE: begin
          next_io_base_hi = cfg_wdata_i[`HPB_IO_MSB:`HPB_IO_LSB]; // [R12] [R14]
        end
        `HPB_OFF_IO_LIMIT: begin
          next_io_limit_hi = cfg_wdata_i[`HPB_IO_MSB:`HPB_IO_LSB]; // [R13] [R14]
        end
        default: begin
          next_io_limit_hi = io_limit_hi; // [R16]
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      downstream_bus_number <= `HPB_DOWN_BUS_RST;
      highest_bus_below <= `HPB_SUB_BUS_RST;
      latency_count <= `HPB_SEC_LAT_RST;
      io_base_hi <= `HPB_IO_BASE_RST;
      io_limit_hi <= `HPB_IO_LIMIT_RST;
    end else begin
      downstream_bus_number <= next_downstream_bus_number;
      highest_bus_below <= next_highest_bus_below;
      latency_count <= next_latency_count;
      io_base_hi <= next_io_base_hi;
      io_limit_hi <= next_io_limit_hi;
    end
  end

  // ------------------------------------------------------------------
  // Configuration read path and completion
  // ------------------------------------------------------------------

  // Read data holds its last value between reads so the hub side may
  // sample it any time after the completion pulse.
  always_comb begin
    next_cfg_done = cfg_valid_i;
    next_cfg_rdata = cfg_rdata;
    if (rd_en) begin
      next_cfg_rdata = read_image(cfg_offset_i, REVISION_CODE,
                                  downstream_bus_number, highest_bus_below,
                                  latency_count, io_base_hi,
                                  io_limit_hi); // [R1] [R2] [R3] [R4] [R5] [R6]
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      cfg_done <= 1'b0;
      cfg_rdata <= 8'h00;
    end else begin
      cfg_done <= next_cfg_done;
      cfg_rdata <= next_cfg_rdata;
    end
  end

  assign cfg_done_o = cfg_done;
  assign cfg_rdata_o = cfg_rdata;

  // ------------------------------------------------------------------
  // Window and bus numbers seen by the forwarding logic
  // ------------------------------------------------------------------

  logic [15:0] io_window_lo;
  logic [15:0] io_window_hi;

  assign io_window_lo = {io_base_hi, `HPB_IO_BASE_PAD}; // [R12]
  assign io_window_hi = {io_limit_hi, `HPB_IO_LIMIT_PAD}; // [R13]

  assign downstream_bus_number_o = downstream_bus_number;
  assign highest_bus_below_o = highest_bus_below;
  assign io_window_lo_o = io_window_lo;
  assign io_window_hi_o = io_window_hi;

  // ------------------------------------------------------------------
  // Cycle decode
  // ------------------------------------------------------------------

  // A base above the limit leaves the window empty, which is how
  // software turns I/O forwarding off.
  hpb_cycle_decode u_decode (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .downstream_bus_i(downstream_bus_number),
    .subordinate_bus_i(highest_bus_below),
    .io_window_lo_i(io_window_lo),
    .io_window_hi_i(io_window_hi),
    .cfg_cycle_valid_i(hub_cfg_valid_i),
    .cfg_cycle_bus_i(hub_cfg_bus_i),
    .io_cycle_valid_i(hub_io_valid_i),
    .io_cycle_addr_i(hub_io_addr_i),
    .cfg_result_valid_o(hub_cfg_result_o),
    .cfg_as_type0_o(hub_cfg_type0_o),
    .cfg_as_type1_o(hub_cfg_type1_o),
    .cfg_master_abort_o(hub_cfg_abort_o),
    .io_result_valid_o(hub_io_result_o),
    .io_forward_o(hub_io_forward_o)
  );

  // ------------------------------------------------------------------
  // Secondary master tenure
  // ------------------------------------------------------------------

  // A count of zero expires at once, so the bridge gives up the bus on
  // the first clock after losing the grant.
  hpb_tenure_timer u_tenure (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .frame_start_i(frame_start_i),
    .frame_active_i(frame_active_i),
    .grant_i(grant_i),
    .latency_count_i(latency_count),
    .tenure_expired_o(tenure_expired_o),
    .frame_release_o(frame_release_o),
    .tenure_counter_o()
  );

endmodule

// [tb/hpb_pci_agent.sv]
// Behavioural PCI-side master engine that feeds the tenure counter.
// Assumes the bench raises go_i for one cycle to start a tenure.
`timescale 1ns/1ns

module hpb_pci_agent (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Bench control
  input wire logic go_i,
  input wire logic stop_i,
  // From the bridge
  input wire logic frame_release_i,
  // To the bridge
  output logic frame_start_o,
  output logic frame_active_o
);
  // FRAME# is asserted together with the start pulse, as a granted master does.
  always @(posedge clk_i) begin
    if (reset_i) begin
      frame_start_o <= 1'b0;
      frame_active_o <= 1'b0;
    end else if (go_i) begin
      frame_start_o <= 1'b1;
      frame_active_o <= 1'b1;
    end else begin
      frame_start_o <= 1'b0;
      if (frame_release_i || stop_i) frame_active_o <= 1'b0;
    end
  end
endmodule

// [tb/hpb_config_header_properties.sv]
// Checker for the bridge configuration header, bound to its top module.
// Assumes one clock domain and the synchronous reset of that domain.
`timescale 1ns/1ns
`include "hpb_consts.svh"

module hpb_config_header_checker (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Watched ports
  input wire logic cfg_valid_i,
  input wire logic cfg_write_i,
  input wire logic [7:0] cfg_offset_i,
  input wire logic [7:0] cfg_wdata_i,
  input wire logic cfg_done_o,
  input wire logic [7:0] cfg_rdata_o,
  input wire logic hub_cfg_valid_i,
  input wire logic [7:0] hub_cfg_bus_i,
  input wire logic hub_cfg_result_o,
  input wire logic hub_cfg_type0_o,
  input wire logic hub_cfg_type1_o,
  input wire logic hub_cfg_abort_o,
  input wire logic hub_io_valid_i,
  input wire logic [15:0] hub_io_addr_i,
  input wire logic hub_io_result_o,
  input wire logic hub_io_forward_o,
  input wire logic frame_start_i,
  input wire logic frame_active_i,
  input wire logic grant_i,
  input wire logic tenure_expired_o,
  input wire logic frame_release_o,
  input wire logic [7:0] downstream_bus_number_o,
  input wire logic [7:0] highest_bus_below_o,
  input wire logic [15:0] io_window_lo_o,
  input wire logic [15:0] io_window_hi_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  // Copy of the latency count field, kept from the writes seen on the port.
  // A zero count expires at the load edge, so the load checks depend on it.
  logic [4:0] lat_shadow;
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      lat_shadow <= `HPB_SEC_LAT_RST;
    end else if (cfg_valid_i && cfg_write_i && cfg_offset_i == `HPB_OFF_SEC_LAT) begin
      lat_shadow <= cfg_wdata_i[`HPB_LAT_MSB:`HPB_LAT_LSB];
    end
  end

  a_done_follows: assert property (cfg_valid_i |=> cfg_done_o)
    else $error("config access without completion");
  a_done_single: assert property (!cfg_valid_i |=> !cfg_done_o)
    else $error("completion without access");
  a_upstream_zero: assert property (cfg_valid_i && !cfg_write_i
    && cfg_offset_i == `HPB_OFF_UP_BUS |=> cfg_rdata_o == 8'h00)
    else $error("primary bus number not zero");
  a_header_layout: assert property (cfg_valid_i && !cfg_write_i
    && cfg_offset_i == `HPB_OFF_HEADER |=> cfg_rdata_o == 8'h01)
    else $error("header type wrong");
  a_base_padding: assert property (io_window_lo_o[11:0] == 12'h000)
    else $error("window start low bits not zero");
  a_limit_padding: assert property (io_window_hi_o[11:0] == 12'hfff)
    else $error("window end low bits not ones");
  a_decode_onehot: assert property (hub_cfg_valid_i |=> hub_cfg_result_o
    && $onehot({hub_cfg_type0_o, hub_cfg_type1_o, hub_cfg_abort_o}))
    else $error("config decode not one result");
  a_abort_range: assert property (hub_cfg_valid_i && (hub_cfg_bus_i <
    downstream_bus_number_o || hub_cfg_bus_i > highest_bus_below_o) |=> hub_cfg_abort_o)
    else $error("out of range bus not aborted");
  a_io_inside: assert property (hub_io_valid_i && hub_io_addr_i >= io_window_lo_o
    && hub_io_addr_i <= io_window_hi_o |=> hub_io_result_o && hub_io_forward_o)
    else $error("inside address not forwarded");
  a_io_outside: assert property (hub_io_valid_i && (hub_io_addr_i < io_window_lo_o
    || hub_io_addr_i > io_window_hi_o) |=> hub_io_result_o && !hub_io_forward_o)
    else $error("outside address forwarded");
  a_no_early_expiry: assert property (frame_start_i && lat_shadow != 5'h00
    |=> !tenure_expired_o)
    else $error("expired at load");
  a_zero_expires: assert property (frame_start_i && lat_shadow == 5'h00
    |=> tenure_expired_o)
    else $error("zero count did not expire at load");
  a_release_needed: assert property (tenure_expired_o && frame_active_i
    && !grant_i |-> frame_release_o)
    else $error("frame not released after expiry");
  a_grant_keeps: assert property (grant_i |-> !frame_release_o)
    else $error("frame released while granted");
endmodule

bind hpb_config_header hpb_config_header_checker u_chk (.clk_i, .reset_i, .cfg_valid_i,
  .cfg_write_i, .cfg_offset_i, .cfg_wdata_i, .cfg_done_o, .cfg_rdata_o, .hub_cfg_valid_i,
  .hub_cfg_bus_i,
  .hub_cfg_result_o, .hub_cfg_type0_o, .hub_cfg_type1_o, .hub_cfg_abort_o, .hub_io_valid_i,
  .hub_io_addr_i, .hub_io_result_o, .hub_io_forward_o, .frame_start_i, .frame_active_i,
  .grant_i, .tenure_expired_o, .frame_release_o, .downstream_bus_number_o,
  .highest_bus_below_o, .io_window_lo_o, .io_window_hi_o);

// [tb/hpb_config_header_tb.sv]
// Self-checking bench for the bridge configuration header.
// Assumes the PCI agent model and the bound checker are compiled first.
`timescale 1ns/1ns

module hpb_config_header_tb;
  localparam logic [7:0] REV = 8'h3c; // Arbitrary revision value.
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cv = 1'b0, cw = 1'b0, done, hv = 1'b0, hres, t0, t1, ab, iv = 1'b0, ires, fwd;
  logic [7:0] coff = 8'h00, cwd = 8'h00, crd, hbus = 8'h00, dbus, sbus, r;
  logic [15:0] ioa = 16'h0000, wlo, whi;
  logic fstart, factive, grant = 1'b0, expd, frel, go = 1'b0, stop = 1'b0;
  int n_mismatch = 0, n_tests = 0, n;
  logic [7:0] offs [12] = '{8'h08, 8'h0a, 8'h0b, 8'h0d, 8'h0e, 8'h18, 8'h19, 8'h1a, 8'h1b,
    8'h1c, 8'h1d, 8'h20};
  logic [7:0] rst_v [12] = '{REV, 8'h04, 8'h06, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00,
    8'hf0, 8'h00, 8'h00};
  logic [7:0] ff_v [12] = '{REV, 8'h04, 8'h06, 8'h00, 8'h01, 8'h00, 8'hff, 8'hff, 8'hf8,
    8'hf0, 8'hf0, 8'h00};
  // Decode cases: secondary, subordinate, bus, expected {type0, type1, abort}.
  logic [7:0] d_sec [7] = '{8'h00, 8'h00, 8'h00, 8'h05, 8'h05, 8'h05, 8'h05};
  logic [7:0] d_sub [7] = '{8'h03, 8'h03, 8'h03, 8'h07, 8'h07, 8'h07, 8'h07};
  logic [7:0] d_bus [7] = '{8'h00, 8'h03, 8'h04, 8'h05, 8'h07, 8'h04, 8'h08};
  logic [2:0] d_exp [7] = '{3'h2, 3'h2, 3'h1, 3'h4, 3'h2, 3'h1, 3'h1};
  logic [15:0] io_a [4] = '{16'h1fff, 16'h2000, 16'h4fff, 16'h5000};
  logic io_e [4] = '{1'b0, 1'b1, 1'b1, 1'b0};

  hpb_config_header #(.REVISION_CODE(REV)) u_dut (.clk_i(clk), .reset_i(rst),
    .cfg_valid_i(cv), .cfg_write_i(cw), .cfg_offset_i(coff), .cfg_wdata_i(cwd),
    .cfg_done_o(done), .cfg_rdata_o(crd), .hub_cfg_valid_i(hv), .hub_cfg_bus_i(hbus),
    .hub_cfg_result_o(hres), .hub_cfg_type0_o(t0), .hub_cfg_type1_o(t1),
    .hub_cfg_abort_o(ab), .hub_io_valid_i(iv), .hub_io_addr_i(ioa), .hub_io_result_o(ires),
    .hub_io_forward_o(fwd), .frame_start_i(fstart), .frame_active_i(factive),
    .grant_i(grant), .tenure_expired_o(expd), .frame_release_o(frel),
    .downstream_bus_number_o(dbus), .highest_bus_below_o(sbus), .io_window_lo_o(wlo),
    .io_window_hi_o(whi));

  hpb_pci_agent u_agent (.clk_i(clk), .reset_i(rst), .go_i(go), .stop_i(stop),
    .frame_release_i(frel), .frame_start_o(fstart), .frame_active_o(factive));

  initial begin
    forever #4 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Access and compare tasks
  // ----------------------------------------------------------------
  task tick;
    @(posedge clk);
    #1;
  endtask

  task print_verdict;
    $display("counts: %0d compares, %0d mismatches", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask

  // Each access holds its request for the taking edge, checks the answer, then idles a cycle.
  task cfg_acc(input logic wr, input logic [7:0] off, input logic [7:0] wd);
    cv = 1'b1;
    cw = wr;
    coff = off;
    cwd = wd;
    tick;
    cv = 1'b0;
    chk(16'(done), 16'h1, "completion");
    r = crd;
    tick;
  endtask

  task cfg_rd(input logic [7:0] off, input logic [7:0] exp);
    cfg_acc(1'b0, off, 8'h00);
    chk(16'(r), 16'(exp), "register read");
  endtask

  task reset_all;
    rst = 1'b1;
    repeat (4) tick;
    rst = 1'b0;
  endtask

  task tenure(input logic [4:0] cnt, input logic g);
    cfg_acc(1'b1, 8'h1b, {cnt, 3'h5});
    grant = g;
    go = 1'b1;
    tick;
    go = 1'b0;
    chk(16'(fstart), 16'h1, "frame start");
    for (n = 1; n <= 300; n++) begin
      tick;
      if (expd === 1'b1) break;
    end
    if (n > 300) begin
      n_mismatch++;
      print_verdict;
    end
    chk(16'(n), 16'(cnt) * 16'd8 + 16'd1, "expiry time");
    chk(16'(frel), 16'(!g), "frame release");
    tick;
    chk(16'(factive), 16'(g), "bus ownership");
    stop = 1'b1;
    tick;
    stop = 1'b0;
    tick;
    chk(16'(expd), 16'h0, "counter idle");
  endtask

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    reset_all;
    for (int i = 0; i < 12; i++) cfg_rd(offs[i], rst_v[i]);
    chk(wlo, 16'hf000, "window start");
    chk(whi, 16'h0fff, "window end");
    $display("test reset values done");
    for (int i = 0; i < 12; i++) cfg_acc(1'b1, offs[i], 8'hff);
    for (int i = 0; i < 12; i++) cfg_rd(offs[i], ff_v[i]);
    chk(whi, 16'hffff, "window end");
    reset_all;
    for (int i = 0; i < 12; i++) cfg_rd(offs[i], rst_v[i]);
    $display("test write masks done");
    for (int i = 0; i < 7; i++) begin
      cfg_acc(1'b1, 8'h19, d_sec[i]);
      cfg_acc(1'b1, 8'h1a, d_sub[i]);
      hbus = d_bus[i];
      hv = 1'b1;
      tick;
      hv = 1'b0;
      chk(16'(hres), 16'h1, "decode result");
      chk(16'({t0, t1, ab}), 16'(d_exp[i]), "decode kind");
      chk(16'(dbus), 16'(d_sec[i]), "secondary bus out");
      chk(16'(sbus), 16'(d_sub[i]), "subordinate bus out");
      tick;
    end
    $display("test bus decode done");
    cfg_acc(1'b1, 8'h1c, 8'h25);
    cfg_acc(1'b1, 8'h1d, 8'h47);
    cfg_rd(8'h1c, 8'h20);
    cfg_rd(8'h1d, 8'h40);
    chk(wlo, 16'h2000, "window start");
    chk(whi, 16'h4fff, "window end");
    for (int i = 0; i < 4; i++) begin
      ioa = io_a[i];
      iv = 1'b1;
      tick;
      iv = 1'b0;
      chk(16'({ires, fwd}), {15'h1, io_e[i]}, "io decode");
      tick;
    end
    $display("test io window done");
    tenure(5'h01, 1'b0);
    tenure(5'h02, 1'b1);
    tenure(5'h00, 1'b0);
    $display("test tenure counter done");
    print_verdict;
  end
endmodule
